// [crs_register_set.sv]
// CPU register set with condition flags, stack pointer and stack sequences
`timescale 1ns/10ps
module crs_register_set
    import crs_pkg::*;
#(
    parameter int IRQ_LINES = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire crs_wr_type reg_wr,
    input wire crs_sel_type rd_sel,
    input wire crs_flag_cmd_type flag_cmd,
    input wire crs_alu_type alu_result,
    input wire logic ip_load,
    input wire logic [15:0] ip_next,
    input wire crs_stack_cmd_type stack_cmd,
    input wire logic [7:0] push_data,
    input wire logic [7:0] mem_rd_data,
    input wire logic [IRQ_LINES-1:0] irq_req,
    input wire logic [IRQ_LINES-1:0] irq_ack,
    output crs_mem_type stack_mem,
    output logic [7:0] rd_data,
    output logic [7:0] accumulator,
    output logic [7:0] index_x,
    output logic [7:0] index_y,
    output logic [15:0] instruction_pointer,
    output logic [7:0] condition_flags,
    output logic [15:0] stack_pointer,
    output logic [7:0] pop_data,
    output logic pop_valid,
    output logic seq_busy,
    output logic [IRQ_LINES-1:0] irq_pending,
    output logic irq_take
);

    // ==========================================
    // Internal state
    logic [7:0] acc_reg;
    logic [7:0] x_reg;
    logic [7:0] y_reg;
    logic [7:0] ipl_reg;
    logic [7:0] iph_reg;
    logic [4:0] flags_reg;
    logic [6:0] sp_reg;
    crs_state_type state_reg;
    logic [2:0] step_reg;
    logic [2:0] last_reg;
    logic irq_seq_reg;
    logic [IRQ_LINES-1:0] pend_reg;
    logic [7:0] flags_full;
    logic seq_write;
    logic [7:0] seq_byte;
    logic [7:0] seq_push_byte;
    logic pop_active;

    // Full pointer from fixed and variable bits
    function automatic logic [15:0] full_sp(input logic [6:0] low);
        full_sp = {CRS_SP_FIXED, low};
    endfunction

    // Byte pushed at each interrupt entry step
    function automatic logic [7:0] irq_byte(input logic [2:0] step,
                                            input logic [7:0] ipl,
                                            input logic [7:0] iph,
                                            input logic [7:0] xv,
                                            input logic [7:0] av,
                                            input logic [7:0] fv);
        case (step)
            3'h0: irq_byte = ipl;
            3'h1: irq_byte = iph;
            3'h2: irq_byte = xv;
            3'h3: irq_byte = av;
            default: irq_byte = fv;
        endcase
    endfunction

    assign flags_full = {CRS_FLAG_ONES, flags_reg};
    assign pop_active = (state_reg == CRS_POP_SEQ);
    assign seq_write = reg_wr.en && !pop_active;

    // Byte for current push step
    always_comb begin
        if (irq_seq_reg) begin
            // Y is never part of the context
            seq_push_byte = irq_byte(step_reg, ipl_reg, iph_reg, x_reg,
                                     acc_reg, flags_full);
        end else if (step_reg == 3'h0) begin
            seq_push_byte = ipl_reg;
        end else begin
            seq_push_byte = iph_reg;
        end
    end

    // Popped byte
    always_comb begin
        seq_byte = mem_rd_data;
    end

    // ==========================================
    // Stack sequencer
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= CRS_IDLE;
            step_reg <= 3'h0;
            last_reg <= 3'h0;
            irq_seq_reg <= 1'b0;
        end else begin
            case (state_reg)
                CRS_IDLE: begin
                    step_reg <= 3'h0;
                    case (stack_cmd)
                        CRS_ST_IRQ_ENTRY: begin
                            state_reg <= CRS_PUSH_SEQ;
                            last_reg <= CRS_IRQ_LAST;
                            irq_seq_reg <= 1'b1;
                        end
                        CRS_ST_CALL: begin
                            state_reg <= CRS_PUSH_SEQ;
                            last_reg <= CRS_CALL_LAST;
                            irq_seq_reg <= 1'b0;
                        end
                        CRS_ST_IRQ_RETURN: begin
                            state_reg <= CRS_POP_SEQ;
                            last_reg <= CRS_IRQ_LAST;
                            irq_seq_reg <= 1'b1;
                        end
                        CRS_ST_RETURN: begin
                            state_reg <= CRS_POP_SEQ;
                            last_reg <= CRS_CALL_LAST;
                            irq_seq_reg <= 1'b0;
                        end
                        default: begin
                            state_reg <= CRS_IDLE;
                        end
                    endcase
                end
                CRS_PUSH_SEQ, CRS_POP_SEQ: begin
                    if (step_reg == last_reg) begin
                        state_reg <= CRS_IDLE;
                    end else begin
                        step_reg <= step_reg + 3'h1;
                    end
                end
                default: begin
                    state_reg <= CRS_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Stack pointer: 7 variable bits, wraps silently
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sp_reg <= CRS_SP_LOW_RESET;
        end else if (state_reg == CRS_PUSH_SEQ) begin
            sp_reg <= sp_reg - 7'h01;
        end else if (state_reg == CRS_POP_SEQ) begin
            sp_reg <= sp_reg + 7'h01;
        end else if (stack_cmd == CRS_ST_REINIT) begin
            sp_reg <= CRS_SP_LOW_RESET;
        end else if (stack_cmd == CRS_ST_PUSH) begin
            sp_reg <= sp_reg - 7'h01;
        end else if (stack_cmd == CRS_ST_POP) begin
            sp_reg <= sp_reg + 7'h01;
        end else if (seq_write && reg_wr.sel == CRS_SEL_SP_LOW) begin
            sp_reg <= reg_wr.data[6:0];
        end
    end

    // ==========================================
    // Memory port; pop addresses the incremented pointer
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stack_mem <= '0;
        end else begin
            stack_mem.wr <= 1'b0;
            stack_mem.rd <= 1'b0;
            if (state_reg == CRS_PUSH_SEQ) begin
                stack_mem.wr <= 1'b1;
                stack_mem.addr <= full_sp(sp_reg);
                stack_mem.data <= seq_push_byte;
            end else if (state_reg == CRS_POP_SEQ) begin
                stack_mem.rd <= 1'b1;
                stack_mem.addr <= full_sp(sp_reg + 7'h01);
            end else if (stack_cmd == CRS_ST_PUSH) begin
                stack_mem.wr <= 1'b1;
                stack_mem.addr <= full_sp(sp_reg);
                stack_mem.data <= push_data;
            end else if (stack_cmd == CRS_ST_POP) begin
                stack_mem.rd <= 1'b1;
                stack_mem.addr <= full_sp(sp_reg + 7'h01);
            end
        end
    end

    // Pop step delayed twice to meet returned data
    logic pop_rx_reg;
    logic pop_irq_reg;
    logic [2:0] pop_step_reg;
    logic [5:0] late_reg;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pop_rx_reg <= 1'b0;
            pop_irq_reg <= 1'b0;
            pop_step_reg <= 3'h0;
            late_reg <= 6'h00;
        end else begin
            pop_rx_reg <= pop_active;
            pop_irq_reg <= irq_seq_reg;
            pop_step_reg <= last_reg - step_reg;
            late_reg <= {stack_mem.rd && !pop_rx_reg, pop_rx_reg,
                         pop_irq_reg, pop_step_reg};
        end
    end

    // Plain pop data returned to the sequencer
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pop_data <= 8'h00;
            pop_valid <= 1'b0;
        end else begin
            pop_valid <= late_reg[5];
            pop_data <= mem_rd_data;
        end
    end

    // ==========================================
    // Accumulator and index registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_reg <= 8'h00;
            x_reg <= 8'h00;
            y_reg <= 8'h00;
        end else if (late_reg[4] && late_reg[3]) begin
            // Restore context; Y untouched
            if (late_reg[2:0] == 3'h3) begin
                acc_reg <= seq_byte;
            end
            if (late_reg[2:0] == 3'h2) begin
                x_reg <= seq_byte;
            end
        end else if (seq_write) begin
            case (reg_wr.sel)
                CRS_SEL_ACC: acc_reg <= reg_wr.data;
                CRS_SEL_X: x_reg <= reg_wr.data;
                CRS_SEL_Y: y_reg <= reg_wr.data;
                default: acc_reg <= acc_reg;
            endcase
        end
    end

    // ==========================================
    // Instruction pointer halves
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ipl_reg <= 8'h00;
            iph_reg <= 8'h00;
        end else if (late_reg[4] && late_reg[2:0] == 3'h0) begin
            ipl_reg <= seq_byte;
        end else if (late_reg[4] && late_reg[2:0] == 3'h1) begin
            iph_reg <= seq_byte;
        end else if (ip_load) begin
            {iph_reg, ipl_reg} <= ip_next;
        end else if (seq_write && reg_wr.sel == CRS_SEL_IP_LOW) begin
            ipl_reg <= reg_wr.data;
        end else if (seq_write && reg_wr.sel == CRS_SEL_IP_HIGH) begin
            iph_reg <= reg_wr.data;
        end
    end

    // ==========================================
    // Condition flags
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_reg <= CRS_FLAGS_RESET[4:0];
        end else if (stack_cmd == CRS_ST_IRQ_ENTRY && state_reg == CRS_IDLE)
        begin
            flags_reg[CRS_FLAG_MASK] <= 1'b1;
        end else if (late_reg[4] && late_reg[3] && late_reg[2:0] == 3'h4) begin
            flags_reg <= mem_rd_data[4:0];
            flags_reg[CRS_FLAG_MASK] <= 1'b0;
        end else if (seq_write && reg_wr.sel == CRS_SEL_FLAGS) begin
            flags_reg <= reg_wr.data[4:0];
        end else begin
            case (flag_cmd)
                CRS_FC_ADD: begin
                    flags_reg[CRS_FLAG_HALF] <= alu_result.half;
                    flags_reg[CRS_FLAG_CARRY] <= alu_result.carry;
                    flags_reg[CRS_FLAG_NEG] <= alu_result.value[7];
                    flags_reg[CRS_FLAG_ZERO] <= alu_result.value == 8'h00;
                end
                CRS_FC_ARITH, CRS_FC_SHIFT: begin
                    flags_reg[CRS_FLAG_CARRY] <= alu_result.carry;
                    flags_reg[CRS_FLAG_NEG] <= alu_result.value[7];
                    flags_reg[CRS_FLAG_ZERO] <= alu_result.value == 8'h00;
                end
                CRS_FC_LOGIC: begin
                    flags_reg[CRS_FLAG_NEG] <= alu_result.value[7];
                    flags_reg[CRS_FLAG_ZERO] <= alu_result.value == 8'h00;
                end
                CRS_FC_BIT_TEST: flags_reg[CRS_FLAG_CARRY] <= alu_result.carry;
                CRS_FC_CARRY_SET: flags_reg[CRS_FLAG_CARRY] <= 1'b1;
                CRS_FC_CARRY_CLR: flags_reg[CRS_FLAG_CARRY] <= 1'b0;
                CRS_FC_MASK_SET: flags_reg[CRS_FLAG_MASK] <= 1'b1;
                CRS_FC_MASK_CLR: flags_reg[CRS_FLAG_MASK] <= 1'b0;
                default: flags_reg <= flags_reg;
            endcase
        end
    end

    // ==========================================
    // Pending requests; a new request beats its acknowledge
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_reg <= '0;
            irq_take <= 1'b0;
        end else begin
            pend_reg <= (pend_reg & ~irq_ack) | irq_req;
            irq_take <= (|pend_reg) && !flags_reg[CRS_FLAG_MASK]
                        && state_reg == CRS_IDLE;
        end
    end

    // ==========================================
    // Register outputs and direct read port
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= 8'h00;
            accumulator <= 8'h00;
            index_x <= 8'h00;
            index_y <= 8'h00;
            instruction_pointer <= 16'h0000;
            condition_flags <= CRS_FLAGS_RESET;
            stack_pointer <= CRS_SP_RESET;
            seq_busy <= 1'b0;
            irq_pending <= '0;
        end else begin
            accumulator <= acc_reg;
            index_x <= x_reg;
            index_y <= y_reg;
            instruction_pointer <= {iph_reg, ipl_reg};
            condition_flags <= flags_full;
            stack_pointer <= full_sp(sp_reg);
            seq_busy <= (state_reg != CRS_IDLE);
            irq_pending <= pend_reg;
            // Only dedicated selectors reach the registers
            case (rd_sel)
                CRS_SEL_ACC: rd_data <= acc_reg;
                CRS_SEL_X: rd_data <= x_reg;
                CRS_SEL_Y: rd_data <= y_reg;
                CRS_SEL_FLAGS: rd_data <= flags_full;
                CRS_SEL_SP_LOW: rd_data <= {1'b0, sp_reg};
                CRS_SEL_IP_LOW: rd_data <= ipl_reg;
                CRS_SEL_IP_HIGH: rd_data <= iph_reg;
                default: rd_data <= 8'h00;
            endcase
        end
    end

endmodule

// [crs_pkg.sv]
// Package for the CPU register set: widths, reset values, commands
package crs_pkg;

    // ==========================================
    // Condition flag layout
    localparam int CRS_FLAG_HALF = 4;
    localparam int CRS_FLAG_MASK = 3;
    localparam int CRS_FLAG_NEG = 2;
    localparam int CRS_FLAG_ZERO = 1;
    localparam int CRS_FLAG_CARRY = 0;
    localparam logic [2:0] CRS_FLAG_ONES = 3'h7;
    localparam logic [7:0] CRS_FLAGS_RESET = 8'he8;

    // ==========================================
    // Stack pointer layout
    localparam logic [8:0] CRS_SP_FIXED = 9'h002;
    localparam logic [6:0] CRS_SP_LOW_RESET = 7'h7f;
    localparam logic [15:0] CRS_SP_RESET = 16'h017f;
    localparam int CRS_CALL_BYTES = 2;
    localparam int CRS_IRQ_BYTES = 5;
    localparam logic [2:0] CRS_IRQ_LAST = 3'h4;
    localparam logic [2:0] CRS_CALL_LAST = 3'h1;

    // ==========================================
    // Register selectors for direct load and store
    typedef enum logic [2:0] {
        CRS_SEL_ACC = 3'h0,
        CRS_SEL_X = 3'h1,
        CRS_SEL_Y = 3'h2,
        CRS_SEL_FLAGS = 3'h3,
        CRS_SEL_SP_LOW = 3'h4,
        CRS_SEL_IP_LOW = 3'h5,
        CRS_SEL_IP_HIGH = 3'h6,
        CRS_SEL_NONE = 3'h7
    } crs_sel_type;

    // Flag commands from the sequencer
    typedef enum logic [3:0] {
        CRS_FC_NONE = 4'h0,
        CRS_FC_ADD = 4'h1,
        CRS_FC_ARITH = 4'h2,
        CRS_FC_LOGIC = 4'h3,
        CRS_FC_SHIFT = 4'h4,
        CRS_FC_CARRY_SET = 4'h5,
        CRS_FC_CARRY_CLR = 4'h6,
        CRS_FC_MASK_SET = 4'h7,
        CRS_FC_MASK_CLR = 4'h8,
        CRS_FC_BIT_TEST = 4'h9
    } crs_flag_cmd_type;

    // Stack sequences
    typedef enum logic [2:0] {
        CRS_ST_NONE = 3'h0,
        CRS_ST_IRQ_ENTRY = 3'h1,
        CRS_ST_IRQ_RETURN = 3'h2,
        CRS_ST_CALL = 3'h3,
        CRS_ST_RETURN = 3'h4,
        CRS_ST_PUSH = 3'h5,
        CRS_ST_POP = 3'h6,
        CRS_ST_REINIT = 3'h7
    } crs_stack_cmd_type;

    typedef enum logic [2:0] {
        CRS_IDLE = 3'h0,
        CRS_PUSH_SEQ = 3'h1,
        CRS_POP_SEQ = 3'h2
    } crs_state_type;

    // ALU result bundle
    typedef struct packed {
        logic [7:0] value;
        logic carry;
        logic half;
    } crs_alu_type;

    // Register write bundle
    typedef struct packed {
        logic en;
        crs_sel_type sel;
        logic [7:0] data;
    } crs_wr_type;

    // Stack memory port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] data;
    } crs_mem_type;

endpackage

// [crs_stack_model.sv]
// Stack memory model standing on the far side of the register set
`timescale 1ns/10ps
module crs_stack_model
    import crs_pkg::*;
(
    input wire logic ref_clk,
    input wire crs_mem_type stack_mem,
    output logic [7:0] mem_rd_data
);
    logic [7:0] mem [0:127];

    initial mem_rd_data = 8'h00;

    // ==========================================
    // Byte store; read data one cycle after rd
    always @(posedge ref_clk) begin
        if (stack_mem.wr) begin
            mem[stack_mem.addr[6:0]] <= stack_mem.data;
        end
        if (stack_mem.rd) begin
            mem_rd_data <= mem[stack_mem.addr[6:0]];
        end else begin
            mem_rd_data <= ~mem_rd_data;
        end
    end
endmodule

// [crs_register_set_sva.sv]
// Checker for the CPU register set ports, with its bind
`timescale 1ns/10ps
module crs_checker
    import crs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire crs_wr_type reg_wr,
    input wire crs_flag_cmd_type flag_cmd,
    input wire crs_alu_type alu_result,
    input wire crs_stack_cmd_type stack_cmd,
    input wire logic [7:0] push_data,
    input wire logic [7:0] mem_rd_data,
    input wire crs_mem_type stack_mem,
    input wire logic [7:0] condition_flags,
    input wire logic [15:0] stack_pointer,
    input wire logic [7:0] pop_data,
    input wire logic pop_valid,
    input wire logic seq_busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic calm_reg;
    logic quiet;

    // ==========================================
    // No stack traffic last cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            calm_reg <= 1'b1;
        end else begin
            calm_reg <= (stack_cmd == CRS_ST_NONE) && !seq_busy;
        end
    end
    assign quiet = calm_reg && !seq_busy && !reg_wr.en;

    // ==========================================
    // Assertions
    chk_flag_ones:
        assert property (condition_flags[7:5] == CRS_FLAG_ONES)
        else $error("flag bits 7..5 not ones");
    chk_sp_fixed:
        assert property (stack_pointer[15:7] == CRS_SP_FIXED)
        else $error("fixed stack pointer bits changed");
    chk_push_dec:
        assert property (quiet && stack_cmd == CRS_ST_PUSH |=> stack_mem.wr
            && stack_mem.addr == stack_pointer
            && stack_mem.data == $past(push_data)
            ##1 stack_pointer[6:0] == $past(stack_mem.addr[6:0]) - 7'h1)
        else $error("push write or decrement wrong");
    chk_pop_inc:
        assert property (quiet && stack_cmd == CRS_ST_POP |=> stack_mem.rd
            && stack_mem.addr[6:0] == stack_pointer[6:0] + 7'h1
            ##1 stack_pointer == $past(stack_mem.addr))
        else $error("pop increment wrong");
    chk_pop_data:
        assert property (quiet && stack_cmd == CRS_ST_POP |-> ##3 pop_valid
            && pop_data == $past(mem_rd_data))
        else $error("pop data wrong");
    chk_irq_five:
        assert property (quiet && stack_cmd == CRS_ST_IRQ_ENTRY |-> ##2
            (stack_mem.wr && seq_busy && condition_flags[CRS_FLAG_MASK])
            ##1 stack_mem.wr [*4] ##1 !stack_mem.wr)
        else $error("interrupt entry not five writes");
    chk_call_two:
        assert property (quiet && stack_cmd == CRS_ST_CALL |-> ##2
            stack_mem.wr [*2] ##1 !stack_mem.wr)
        else $error("call not two writes");
    chk_reinit_top:
        assert property (quiet && stack_cmd == CRS_ST_REINIT |-> ##2
            stack_pointer == CRS_SP_RESET)
        else $error("stack reinit wrong");
    chk_add_flags:
        assert property (quiet && stack_cmd == CRS_ST_NONE
            && flag_cmd == CRS_FC_ADD |-> ##2
            condition_flags[CRS_FLAG_HALF] == $past(alu_result.half, 2)
            && condition_flags[CRS_FLAG_NEG] == $past(alu_result.value[7], 2)
            && condition_flags[CRS_FLAG_CARRY] == $past(alu_result.carry, 2)
            && condition_flags[CRS_FLAG_ZERO]
            == ($past(alu_result.value, 2) == 8'h00))
        else $error("add flags wrong");

    // Main scenarios reached
    cover property (quiet && stack_cmd == CRS_ST_IRQ_ENTRY);
    cover property (quiet && stack_cmd == CRS_ST_CALL);
    cover property (pop_valid);
endmodule

bind crs_register_set crs_checker chk_u (
    .ref_clk, .reset_n, .reg_wr, .flag_cmd, .alu_result, .stack_cmd,
    .push_data, .mem_rd_data, .stack_mem, .condition_flags,
    .stack_pointer, .pop_data, .pop_valid, .seq_busy
);

// [crs_register_set_bench.sv]
// Self-checking testbench for the CPU register set
`timescale 1ns/10ps
module crs_register_set_bench;
    import crs_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    crs_wr_type reg_wr = '0;
    crs_sel_type rd_sel = CRS_SEL_NONE;
    crs_flag_cmd_type flag_cmd = CRS_FC_NONE;
    crs_alu_type alu_result = '0;
    logic ip_load = 1'b0;
    logic [15:0] ip_next = 16'h0000;
    crs_stack_cmd_type stack_cmd = CRS_ST_NONE;
    logic [7:0] push_data = 8'h00;
    logic [7:0] irq_req = 8'h00;
    logic [7:0] irq_ack = 8'h00;
    logic [7:0] mem_rd_data, rd_data, accumulator, index_x, index_y;
    logic [7:0] condition_flags, pop_data, irq_pending;
    logic [15:0] instruction_pointer, stack_pointer;
    logic pop_valid, seq_busy, irq_take;
    crs_mem_type stack_mem;
    crs_sel_type sels [5] = '{CRS_SEL_ACC, CRS_SEL_X, CRS_SEL_Y,
        CRS_SEL_IP_LOW, CRS_SEL_IP_HIGH};
    logic [7:0] ctx [5] = '{8'h34, 8'h12, 8'h22, 8'h11, 8'he1};
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;

    crs_register_set dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
        .reg_wr(reg_wr), .rd_sel(rd_sel), .flag_cmd(flag_cmd),
        .alu_result(alu_result), .ip_load(ip_load), .ip_next(ip_next),
        .stack_cmd(stack_cmd), .push_data(push_data),
        .mem_rd_data(mem_rd_data), .irq_req(irq_req), .irq_ack(irq_ack),
        .stack_mem(stack_mem), .rd_data(rd_data),
        .accumulator(accumulator), .index_x(index_x), .index_y(index_y),
        .instruction_pointer(instruction_pointer),
        .condition_flags(condition_flags), .stack_pointer(stack_pointer),
        .pop_data(pop_data), .pop_valid(pop_valid), .seq_busy(seq_busy),
        .irq_pending(irq_pending), .irq_take(irq_take));
    crs_stack_model ram_u (.ref_clk(ref_clk), .stack_mem(stack_mem),
        .mem_rd_data(mem_rd_data));

    // ==========================================
    // Clock and hang guard
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt = error_cnt + 1;
            wrap_up();
        end
    end

    // ==========================================
    // Access tasks
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input crs_sel_type s, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= '{1'b1, s, d};
        @(posedge ref_clk);
        reg_wr <= '0;
        tick(1);
    endtask
    task automatic rd(input crs_sel_type s, input logic [7:0] e);
        @(posedge ref_clk);
        rd_sel <= s;
        tick(2);
        chk("rd_data", e, rd_data);
    endtask
    task automatic ipset(input logic [15:0] v);
        @(posedge ref_clk);
        ip_load <= 1'b1;
        ip_next <= v;
        @(posedge ref_clk);
        ip_load <= 1'b0;
        tick(1);
    endtask
    // Stack command; pop expects d
    task automatic stk(input crs_stack_cmd_type c, input logic [7:0] d);
        int n = 0;
        @(posedge ref_clk);
        stack_cmd <= c;
        push_data <= d;
        @(posedge ref_clk);
        stack_cmd <= CRS_ST_NONE;
        tick(2);
        if (c == CRS_ST_POP) begin
            chk("pop_valid", 1, pop_valid);
            chk("pop_data", d, pop_data);
        end
        while (seq_busy !== 1'b0 && n < 20) begin
            tick(1);
            n++;
        end
        chk("seq_busy", 0, seq_busy);
        tick(2);
    endtask
    task automatic fl(input crs_flag_cmd_type c, input logic [9:0] a,
        input logic [7:0] m, input logic [7:0] e);
        @(posedge ref_clk);
        flag_cmd <= c;
        alu_result <= a;
        @(posedge ref_clk);
        flag_cmd <= CRS_FC_NONE;
        tick(1);
        chk("flags", e, condition_flags & m);
    endtask
    task automatic pulse(input logic req);
        @(posedge ref_clk);
        if (req) irq_req <= 8'h04;
        else irq_ack <= 8'h04;
        @(posedge ref_clk);
        irq_req <= 8'h00;
        irq_ack <= 8'h00;
        tick(3);
    endtask

    // ==========================================
    // Test sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        tick(1);
        chk("flags", 8'he8, condition_flags & 8'he8);
        chk("sp", CRS_SP_RESET, stack_pointer);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            wr(sels[i], 8'h5a + 8'(i));
            rd(sels[i], 8'h5a + 8'(i));
        end
        chk("acc", 8'h5a, accumulator);
        chk("x", 8'h5b, index_x);
        chk("y", 8'h5c, index_y);
        chk("ip", 16'h5e5d, instruction_pointer);
        ipset(16'hbeef);
        chk("ip", 16'hbeef, instruction_pointer);
        wr(CRS_SEL_FLAGS, 8'h00);
        rd(CRS_SEL_FLAGS, 8'he0);
        wr(CRS_SEL_SP_LOW, 8'h85);
        chk("sp", 16'h0105, stack_pointer);
        rd(CRS_SEL_SP_LOW, 8'h05);
        stk(CRS_ST_REINIT, 8'h00);
        chk("sp", 16'h017f, stack_pointer);
        $display("test registers done");
        fl(CRS_FC_ADD, {8'h80, 2'b11}, 8'hff, 8'hf5);
        fl(CRS_FC_ADD, {8'h00, 2'b00}, 8'hff, 8'he2);
        fl(CRS_FC_CARRY_SET, 10'h000, 8'hff, 8'he3);
        fl(CRS_FC_CARRY_CLR, 10'h000, 8'hff, 8'he2);
        fl(CRS_FC_MASK_SET, 10'h000, 8'hff, 8'hea);
        fl(CRS_FC_MASK_CLR, 10'h000, 8'hff, 8'he2);
        fl(CRS_FC_LOGIC, {8'h7f, 2'b00}, 8'h06, 8'h00);
        fl(CRS_FC_ARITH, {8'hff, 2'b10}, 8'h07, 8'h05);
        fl(CRS_FC_SHIFT, {8'h00, 2'b10}, 8'h07, 8'h03);
        fl(CRS_FC_BIT_TEST, 10'h000, 8'h01, 8'h00);
        $display("test flags done");
        stk(CRS_ST_PUSH, 8'h3c);
        chk("mem", 8'h3c, ram_u.mem[7'h7f]);
        chk("sp", 16'h017e, stack_pointer);
        stk(CRS_ST_POP, 8'h3c);
        wr(CRS_SEL_SP_LOW, 8'h00);
        stk(CRS_ST_PUSH, 8'h5a);
        chk("sp", 16'h017f, stack_pointer);
        stk(CRS_ST_POP, 8'h5a);
        chk("sp", 16'h0100, stack_pointer);
        stk(CRS_ST_REINIT, 8'h00);
        $display("test stack done");
        wr(CRS_SEL_ACC, 8'h11);
        wr(CRS_SEL_X, 8'h22);
        wr(CRS_SEL_Y, 8'h33);
        ipset(16'h1234);
        wr(CRS_SEL_FLAGS, 8'h01);
        stk(CRS_ST_IRQ_ENTRY, 8'h00);
        chk("sp", 16'h017a, stack_pointer);
        chk("mask", 1, condition_flags[CRS_FLAG_MASK]);
        for (int i = 0; i < 5; i++) begin
            chk("ctx", ctx[i], ram_u.mem[7'h7f - 7'(i)] & 8'hf7);
        end
        wr(CRS_SEL_ACC, 8'h00);
        wr(CRS_SEL_X, 8'h00);
        wr(CRS_SEL_Y, 8'h44);
        ipset(16'h0000);
        stk(CRS_ST_IRQ_RETURN, 8'h00);
        chk("acc", 8'h11, accumulator);
        chk("x", 8'h22, index_x);
        chk("y", 8'h44, index_y);
        chk("ip", 16'h1234, instruction_pointer);
        chk("flags", 8'he1, condition_flags);
        chk("sp", 16'h017f, stack_pointer);
        $display("test interrupt context done");
        ipset(16'habcd);
        stk(CRS_ST_CALL, 8'h00);
        chk("sp", 16'h017d, stack_pointer);
        chk("ret", 16'hcdab, {ram_u.mem[7'h7f], ram_u.mem[7'h7e]});
        ipset(16'h0000);
        stk(CRS_ST_RETURN, 8'h00);
        chk("ip", 16'habcd, instruction_pointer);
        $display("test call done");
        fl(CRS_FC_MASK_SET, 10'h000, 8'h08, 8'h08);
        pulse(1'b1);
        chk("pending", 8'h04, irq_pending);
        chk("take", 0, irq_take);
        fl(CRS_FC_MASK_CLR, 10'h000, 8'h08, 8'h00);
        tick(1);
        chk("take", 1, irq_take);
        pulse(1'b0);
        chk("pending", 8'h00, irq_pending);
        $display("test pending done");
        wrap_up();
    end
endmodule
